// ===== core/ipfs_map.vh
// register map, field layout and function codes of the input pin function select block
`ifndef IPFS_MAP_VH
`define IPFS_MAP_VH

`define IPFS_PAGE 8'h00
`define IPFS_ADDR_MON 8'h2A
`define IPFS_ADDR_SEL_A 8'h2B
`define IPFS_ADDR_SEL_B 8'h2C

`define IPFS_REG_RST 8'h00
`define IPFS_FN_RST 3'h0

`define IPFS_MON_BIT 7
`define IPFS_HI_MSB 6
`define IPFS_HI_LSB 4
`define IPFS_LO_MSB 2
`define IPFS_LO_LSB 0

`define IPFS_FN_OFF 3'h0
`define IPFS_FN_GPI 3'h1
`define IPFS_FN_MCLK 3'h2
`define IPFS_FN_CASC 3'h3
`define IPFS_FN_PDM_A 3'h4
`define IPFS_FN_PDM_B 3'h5
`define IPFS_FN_PDM_C 3'h6
`define IPFS_FN_PDM_D 3'h7

`define IPFS_NUM_PINS 4
`define IPFS_NUM_SYNC 5
`define IPFS_NUM_FN 8

`endif

// ===== core/ipfs_pin_sync.v
// two-flop synchronisers for the input pins and the bidirectional pin
`timescale 1ns/1ps
`include "ipfs_map.vh"

module ipfs_pin_sync (
    input wire clk,
    input wire rst,
    input wire [`IPFS_NUM_SYNC-1:0] pin_async,
    output wire [`IPFS_NUM_SYNC-1:0] pin_sync
);

    genvar g;

    generate
        for (g = 0; g < `IPFS_NUM_SYNC; g = g + 1) begin : g_sync
            reg meta_r;
            reg sync_r;

            // first stage is read only by the second stage
            always @(posedge clk) begin
                if (rst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= pin_async[g];
                    sync_r <= meta_r;
                end
            end

            assign pin_sync[g] = sync_r;
        end
    endgenerate

endmodule // ipfs_pin_sync

// ===== core/ipfs_top.v
// input pin function select: configuration registers, monitor and function routing
//
// Function
// - A read-only monitor register at page 0 address 0x2A reports the bidirectional pin level in bit 7 while that pin is a general input.
// - Bits 6 to 4 of register 0x2B select the function of input pin 1, code 1 meaning general input.
// - Bits 2 to 0 of register 0x2B select the function of input pin 2 with the same codes.
// - Bits 6 to 4 of register 0x2C select the function of input pin 3 with the same codes.
// - Code 0 disables a pin so its activity is ignored, and it is the reset value of every field.
// - Code 2 makes the pin the master reference clock input.
// - Code 3 makes the pin the cascaded serial audio data input for daisy-chaining.
// - Codes 4 to 7 make the pin the PDM data input for channel pairs 1/2, 3/4, 5/6 and 7/8.
// - Bits 2 to 0 of register 0x2C select the function of input pin 4 with the same codes.
`timescale 1ns/1ps
`include "ipfs_map.vh"

module ipfs_top (
    input wire clk,
    input wire rst,
    input wire shared_input_pin1,
    input wire shared_input_pin2,
    input wire shared_input_pin3,
    input wire shared_input_pin4,
    input wire bidir_pin_in,
    input wire bidir_pin_gpi_mode,
    input wire [7:0] reg_page,
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wdata,
    input wire reg_rd_en,
    output wire [7:0] reg_rdata,
    output wire reg_rd_valid,
    output wire [2:0] input_pin1_function,
    output wire [2:0] input_pin2_function,
    output wire [2:0] input_pin3_function,
    output wire [2:0] input_pin4_function,
    output wire [3:0] general_input,
    output wire mclk_in,
    output wire mclk_in_valid,
    output wire cascade_serial_data_in,
    output wire cascade_serial_data_valid,
    output wire pdm_data_in_pair_a,
    output wire pdm_data_in_pair_b,
    output wire pdm_data_in_pair_c,
    output wire pdm_data_in_pair_d,
    output wire [3:0] pdm_pair_valid
);

    // true when a function field holds the given code
    function fn_is;
        input [2:0] code;
        input [2:0] target;
        begin
            fn_is = (code == target);
        end
    endfunction

    wire [`IPFS_NUM_SYNC-1:0] pin_async;
    wire [`IPFS_NUM_SYNC-1:0] pin_sync;
    wire page_hit;

    reg [2:0] fn_r [0:`IPFS_NUM_PINS-1];
    reg bidir_level_r;
    reg [7:0] rdata_r;
    reg rd_valid_r;
    reg [7:0] rdata_nxt;

    reg [3:0] gi_r;
    reg [3:0] gi_nxt;
    reg [`IPFS_NUM_FN-1:0] route_valid_r;
    reg [`IPFS_NUM_FN-1:0] route_level_r;
    reg [`IPFS_NUM_FN-1:0] route_valid_nxt;
    reg [`IPFS_NUM_FN-1:0] route_level_nxt;

    integer i;
    integer j;
    integer k;
    integer f;

    assign pin_async = {bidir_pin_in, shared_input_pin4, shared_input_pin3,
                        shared_input_pin2, shared_input_pin1};

    // bits 3 to 0 carry input pins 4 to 1, bit 4 the bidirectional pin
    ipfs_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .pin_async(pin_async),
        .pin_sync(pin_sync)
    );

    // only page 0 decodes; other pages read zero and ignore writes
    assign page_hit = (reg_page == `IPFS_PAGE);

    // reserved bits 7 and 3 are never stored
    // configuration fields; the monitor register takes no writes
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < `IPFS_NUM_PINS; i = i + 1) begin
                fn_r[i] <= `IPFS_FN_RST;
            end
        end else if (reg_wr_en && page_hit) begin
            case (reg_addr)
                `IPFS_ADDR_SEL_A: begin
                    fn_r[0] <= reg_wdata[`IPFS_HI_MSB:`IPFS_HI_LSB];
                    fn_r[1] <= reg_wdata[`IPFS_LO_MSB:`IPFS_LO_LSB];
                end
                `IPFS_ADDR_SEL_B: begin
                    fn_r[2] <= reg_wdata[`IPFS_HI_MSB:`IPFS_HI_LSB];
                    fn_r[3] <= reg_wdata[`IPFS_LO_MSB:`IPFS_LO_LSB];
                end
                default: begin
                    fn_r[0] <= fn_r[0];
                end
            endcase
        end
    end

    // the mode input is on this clock already and needs no synchroniser
    // monitor follows the synchronised pin only in general input mode, else holds
    always @(posedge clk) begin
        if (rst) begin
            bidir_level_r <= 1'b0;
        end else if (bidir_pin_gpi_mode) begin
            bidir_level_r <= pin_sync[4];
        end
    end

    // read data: reserved bits and unmapped addresses read as zero
    always @* begin
        rdata_nxt = `IPFS_REG_RST;
        if (page_hit) begin
            case (reg_addr)
                `IPFS_ADDR_MON: begin
                    rdata_nxt[`IPFS_MON_BIT] = bidir_level_r;
                end
                `IPFS_ADDR_SEL_A: begin
                    rdata_nxt[`IPFS_HI_MSB:`IPFS_HI_LSB] = fn_r[0];
                    rdata_nxt[`IPFS_LO_MSB:`IPFS_LO_LSB] = fn_r[1];
                end
                `IPFS_ADDR_SEL_B: begin
                    rdata_nxt[`IPFS_HI_MSB:`IPFS_HI_LSB] = fn_r[2];
                    rdata_nxt[`IPFS_LO_MSB:`IPFS_LO_LSB] = fn_r[3];
                end
                default: begin
                    rdata_nxt = `IPFS_REG_RST;
                end
            endcase
        end
    end

    // a read in the cycle of a write returns the old field value
    // read data holds until the next read strobe
    always @(posedge clk) begin
        if (rst) begin
            rdata_r <= `IPFS_REG_RST;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_en;
            if (reg_rd_en) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // per-pin general input level; any other code masks the pin
    always @* begin
        gi_nxt = 4'h0;
        for (j = 0; j < `IPFS_NUM_PINS; j = j + 1) begin
            gi_nxt[j] = fn_is(fn_r[j], `IPFS_FN_GPI) & pin_sync[j];
        end
    end

    // route each shared function to the lowest numbered pin that selects it;
    // a disabled pin never reaches any function
    always @* begin
        route_valid_nxt = 8'h00;
        route_level_nxt = 8'h00;
        for (f = 2; f < `IPFS_NUM_FN; f = f + 1) begin
            for (k = `IPFS_NUM_PINS - 1; k >= 0; k = k - 1) begin
                if (fn_is(fn_r[k], f[2:0])) begin
                    route_valid_nxt[f] = 1'b1;
                    route_level_nxt[f] = pin_sync[k];
                end
            end
        end
    end

    // outputs lag a pin change by three clocks: two sync stages and this register
    always @(posedge clk) begin
        if (rst) begin
            gi_r <= 4'h0;
            route_valid_r <= 8'h00;
            route_level_r <= 8'h00;
        end else begin
            gi_r <= gi_nxt;
            route_valid_r <= route_valid_nxt;
            route_level_r <= route_level_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rd_valid = rd_valid_r;

    // fields drive the outputs straight from the registers, visible right after the write edge
    assign input_pin1_function = fn_r[0];
    assign input_pin2_function = fn_r[1];
    assign input_pin3_function = fn_r[2];
    assign input_pin4_function = fn_r[3];

    assign general_input = gi_r;

    // level outputs read zero while no pin selects their function
    assign mclk_in = route_level_r[`IPFS_FN_MCLK];
    assign mclk_in_valid = route_valid_r[`IPFS_FN_MCLK];

    assign cascade_serial_data_in = route_level_r[`IPFS_FN_CASC];
    assign cascade_serial_data_valid = route_valid_r[`IPFS_FN_CASC];

    assign pdm_data_in_pair_a = route_level_r[`IPFS_FN_PDM_A];
    assign pdm_data_in_pair_b = route_level_r[`IPFS_FN_PDM_B];
    assign pdm_data_in_pair_c = route_level_r[`IPFS_FN_PDM_C];
    assign pdm_data_in_pair_d = route_level_r[`IPFS_FN_PDM_D];
    assign pdm_pair_valid = route_valid_r[`IPFS_FN_PDM_D:`IPFS_FN_PDM_A];

endmodule // ipfs_top

// ===== testbench/ipfs_chk_monitor.sv
// assertion checker on the ports of ipfs_top
`timescale 1ns/1ps
module ipfs_chk_monitor (
    input wire clk,
    input wire rst,
    input wire [7:0] reg_page,
    input wire [7:0] reg_addr,
    input wire reg_wr_en,
    input wire [7:0] reg_wdata,
    input wire reg_rd_en,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid,
    input wire [2:0] input_pin1_function,
    input wire [2:0] input_pin2_function,
    input wire [2:0] input_pin3_function,
    input wire [2:0] input_pin4_function,
    input wire [3:0] general_input,
    input wire mclk_in_valid,
    input wire cascade_serial_data_valid,
    input wire [3:0] pdm_pair_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [11:0] fv = {input_pin1_function, input_pin2_function,
        input_pin3_function, input_pin4_function};
    wire wa = reg_wr_en && reg_page == 8'h00 && reg_addr == 8'h2B;
    wire wb = reg_wr_en && reg_page == 8'h00 && reg_addr == 8'h2C;
    function automatic logic has(input logic [2:0] c, input logic [11:0] v);
        return v[11:9] == c || v[8:6] == c || v[5:3] == c || v[2:0] == c;
    endfunction
    a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered");
    a_mon_low: assert property (reg_rd_valid && $past(reg_addr) == 8'h2A |->
        reg_rdata[6:0] == 7'h00) else $error("monitor low bits set");
    a_rsv_zero: assert property (reg_rd_valid && $past(reg_addr) != 8'h2A |->
        !reg_rdata[7] && !reg_rdata[3]) else $error("reserved bit set");
    a_sel_a: assert property (wa |=> {input_pin1_function, input_pin2_function} ==
        {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}) else $error("select a wrong");
    a_sel_b: assert property (wb |=> {input_pin3_function, input_pin4_function} ==
        {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}) else $error("select b wrong");
    a_gpi_off: assert property ($past(input_pin1_function) != 3'h1 |-> !general_input[0])
        else $error("disabled pin seen");
    a_clk_casc: assert property ({mclk_in_valid, cascade_serial_data_valid} ==
        {$past(has(3'h2, fv)), $past(has(3'h3, fv))}) else $error("clock or cascade wrong");
    a_pdm_sel: assert property (pdm_pair_valid == {$past(has(3'h7, fv)),
        $past(has(3'h6, fv)), $past(has(3'h5, fv)), $past(has(3'h4, fv))})
        else $error("pdm valid wrong");
endmodule // ipfs_chk_monitor

// ===== testbench/ipfs_host.sv
// host model driving the page, address and strobe register port
`timescale 1ns/1ps
module ipfs_host (
    input wire clk,
    output logic [7:0] reg_page,
    output logic [7:0] reg_addr,
    output logic reg_wr_en,
    output logic [7:0] reg_wdata,
    output logic reg_rd_en,
    input wire [7:0] reg_rdata,
    input wire reg_rd_valid
);
    initial {reg_page, reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = 0;
    task automatic wr(input logic [7:0] p, a, d);
        @(posedge clk);
        #1 {reg_page, reg_addr, reg_wdata, reg_wr_en} = {p, a, d, 1'h1};
        @(posedge clk);
        #1 reg_wr_en = 0;
        {reg_page, reg_addr, reg_wdata} = ~{p, a, d};
    endtask
    task automatic rd(input logic [7:0] p, a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        #1 {reg_page, reg_addr, reg_rd_en} = {p, a, 1'h1};
        @(posedge clk);
        #1 {d, ok} = {reg_rdata, reg_rd_valid === 1'h1};
        reg_rd_en = 0;
        {reg_page, reg_addr} = ~{p, a};
    endtask
endmodule // ipfs_host

// ===== testbench/tb_ipfs_top.sv
// self-checking bench for the input pin function select block
`timescale 1ns/1ps
module tb_ipfs_top;
    logic clk = 0, rst = 1, gm = 0, bp = 0, ok, v, l;
    logic [3:0] pin = 0;
    logic [7:0] reg_page, reg_addr, reg_wdata, reg_rdata, rd, d;
    logic reg_wr_en, reg_rd_en, reg_rd_valid;
    wire [3:0] gi;
    wire [5:0] vv, lv;
    int mismatches = 0, total_checks = 0, mon = 0;
    int fn[4] = '{0, 0, 0, 0};
    initial forever #4 clk = ~clk;
    ipfs_host host (.clk, .reg_page, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rdata, .reg_rd_valid);
    ipfs_top uut (.clk, .rst, .shared_input_pin1(pin[0]), .shared_input_pin2(pin[1]),
        .shared_input_pin3(pin[2]), .shared_input_pin4(pin[3]), .bidir_pin_in(bp),
        .bidir_pin_gpi_mode(gm), .reg_page, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rdata, .reg_rd_valid, .input_pin1_function(), .input_pin2_function(),
        .input_pin3_function(), .input_pin4_function(), .general_input(gi),
        .mclk_in(lv[0]), .mclk_in_valid(vv[0]), .cascade_serial_data_in(lv[1]),
        .cascade_serial_data_valid(vv[1]), .pdm_data_in_pair_a(lv[2]),
        .pdm_data_in_pair_b(lv[3]), .pdm_data_in_pair_c(lv[4]),
        .pdm_data_in_pair_d(lv[5]), .pdm_pair_valid(vv[5:2]));
    task automatic chk(input string n, input logic [7:0] e, g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_reg(input string n, input logic [7:0] e, g);
        chk(n, e, g);
    endtask
    task automatic chk_pin(input string n, input logic e, g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [7:0] regv(input logic [7:0] a);
        if (a == 8'h2A) return {mon[0], 7'h00};
        if (a == 8'h2B) return {1'h0, fn[0][2:0], 1'h0, fn[1][2:0]};
        if (a == 8'h2C) return {1'h0, fn[2][2:0], 1'h0, fn[3][2:0]};
        return 8'h00;
    endfunction
    task automatic mwr(input logic [7:0] p, a, x);
        host.wr(p, a, x);
        if (p == 8'h00 && a == 8'h2B) {fn[0], fn[1]} = {29'h0, x[6:4], 29'h0, x[2:0]};
        if (p == 8'h00 && a == 8'h2C) {fn[2], fn[3]} = {29'h0, x[6:4], 29'h0, x[2:0]};
    endtask
    task automatic rdc(input logic [7:0] p, a);
        host.rd(p, a, rd, ok);
        chk_reg("rd_valid", 8'h01, {7'h00, ok});
        chk_reg("rdata", p == 8'h00 ? regv(a) : 8'h00, rd);
    endtask
    task automatic route;
        repeat (5) @(posedge clk);
        #1;
        for (int c = 2; c < 8; c++) begin
            {v, l} = 2'h0;
            for (int i = 3; i >= 0; i--) if (fn[i] == c) {v, l} = {1'h1, pin[i]};
            chk_pin("valid", v, vv[c-2]);
            chk_pin("level", l, lv[c-2]);
        end
        for (int i = 0; i < 4; i++) chk_pin("gpi", fn[i] == 1 && pin[i], gi[i]);
    endtask
    initial begin
        void'($urandom(32'h1b92));
        repeat (3) @(posedge clk);
        #1 rst = 0;
        for (int a = 8'h2A; a < 8'h2E; a++) rdc(8'h00, a[7:0]);
        for (int c = 0; c < 8; c++) begin
            d = $urandom;
            {d[6:4], d[2:0]} = {c[2:0], ~c[2:0]};
            mwr(8'h00, 8'h2B, d);
            d = $urandom;
            {d[6:4], d[2:0]} = {c[2:0] + 3'h2, c[2:0] + 3'h5};
            mwr(8'h00, 8'h2C, d);
            pin = 4'($urandom);
            rdc(8'h00, 8'h2B);
            rdc(8'h00, 8'h2C);
            route;
        end
        mwr(8'h00, 8'h2A, 8'hFF);
        mwr(8'h01, 8'h2B, 8'hFF);
        mwr(8'h00, 8'h2D, 8'hFF);
        rdc(8'h00, 8'h2B);
        rdc(8'h01, 8'h2B);
        gm = 1;
        for (int b = 0; b < 3; b++) begin
            bp = b[0];
            repeat (5) @(posedge clk);
            #1 mon = bp;
            rdc(8'h00, 8'h2A);
        end
        gm = 0;
        bp = ~bp;
        repeat (5) @(posedge clk);
        #1 rdc(8'h00, 8'h2A);
        report_and_stop;
    end
endmodule // tb_ipfs_top
bind ipfs_top ipfs_chk_monitor u_mon (.clk, .rst, .reg_page, .reg_addr, .reg_wr_en,
    .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid, .input_pin1_function,
    .input_pin2_function, .input_pin3_function, .input_pin4_function, .general_input,
    .mclk_in_valid, .cascade_serial_data_valid, .pdm_pair_valid);
